// ---- eac_top.sv ----
/*
  Configuration register bank of the energy accumulation engine and the
  logic that applies it per power sample: voltage routing, accumulation
  shaping, phase B rms source and the peak period zero-crossing count.
  Assumes samples and zero-crossing pulses come from logic on ref_clk,
  and a simple strobed register port with read data one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------------------------------------
// Notes on behaviour
// - Phase C current pairs with voltage C, A or B for pick codes 00, 01, 10.
// - Pick code 11 behaves as code 00, voltage C.
// - Peak enables at bits 2, 3, 4 add phases A, B, C; all reset to one.
// - Crossings on every enabled phase advance the peak period count.
// - Active mode 00 accumulates signed for energy and pulses alike.
// - Active mode 01 keeps only positive power for energy, pulses signed.
// - Active mode 10 behaves as signed mode 00.
// - Active mode 11 uses absolute power for energy and pulses.
// - Reactive mode 00 accumulates signed for energy and pulses alike.
// - Reactive mode 01 behaves as signed mode 00.
// - Reactive mode 10 flips reactive sign when active is negative; pulses signed.
// - Reactive mode 11 uses absolute reactive power for energy, pulses signed.
// - The wiring field picks the phase B voltage; reactive uses the -90 degree currents.
// - Wiring codes 00, 10, 11 are four-wire three-sensor, two-sensor and delta.
// - Wiring 01 feeds the A minus C voltage into the phase B rms result.
// --------------------------------------------------------------------

module eac_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [eac_pkg::ADDR_W-1:0] regAddr,
  input wire logic [eac_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [eac_pkg::DATA_W-1:0] regRdData,
  input wire logic sampleValid,
  input var eac_pkg::eac_samp_s sampleIn,
  input wire logic [2:0] zxPulse,
  output logic powerValid,
  output var eac_pkg::eac_pow_s powerOut,
  output logic [eac_pkg::SAMPLE_W:0] phaseBVoltRms,
  output logic [2:0] peakPhaseEnable,
  output logic peakPeriodEnd,
  output var eac_pkg::eac_cfg_s cfgOut
);
  import eac_pkg::*;

  eac_top_st_s st_r;
  eac_top_st_s st_nxt;
  eac_volt_s volt;
  eac_pow_s powShaped;
  logic [2:0][SAMPLE_W-1:0] iIn;
  logic [2:0][SAMPLE_W-1:0] iqIn;
  logic [2:0][PW-1:0] actP;
  logic [2:0][PW-1:0] reaP;

  // --------------------------------------------------------------------
  // Voltage routing
  // --------------------------------------------------------------------
  // Registered fields are used, so a write lands on samples after its own cycle
  eac_wiring_mux uWiring (
    .samp(sampleIn),
    .wiring(st_r.cfg.wiring),
    .vcPick(st_r.cfg.vcPick),
    .volt(volt)
  );

  assign iIn[0] = sampleIn.iA;
  assign iIn[1] = sampleIn.iB;
  assign iIn[2] = sampleIn.iC;
  assign iqIn[0] = sampleIn.iAq;
  assign iqIn[1] = sampleIn.iBq;
  assign iqIn[2] = sampleIn.iCq;

  // --------------------------------------------------------------------
  // Per-phase powers and shaping
  // --------------------------------------------------------------------
  genvar gPh;
  generate
    for (gPh = 0; gPh < 3; gPh++) begin : gPhase
      logic signed [2*SAMPLE_W:0] actProd;
      logic signed [2*SAMPLE_W:0] reaProd;
      assign actProd = $signed(volt.vPair[gPh]) * $signed(iIn[gPh]);
      assign reaProd = $signed(volt.vPair[gPh]) * $signed(iqIn[gPh]);
      assign actP[gPh] = PW'(actProd);
      assign reaP[gPh] = PW'(reaProd);

      eac_accum_shaper uShaper (
        .actIn(actP[gPh]),
        .reaIn(reaP[gPh]),
        .actMode(st_r.cfg.actMode),
        .reaMode(st_r.cfg.reaMode),
        .actEnergy(powShaped.actEnergy[gPh]),
        .actPulse(powShaped.actPulse[gPh]),
        .reaEnergy(powShaped.reaEnergy[gPh]),
        .reaPulse(powShaped.reaPulse[gPh])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [1:0] zxHits;
    logic [PCYC_W:0] zxSum;
    logic [2:0] zxEn;
    st_nxt = st_r;
    zxEn = '0;
    zxHits = '0;
    zxSum = '0;

    // Register writes
    if (regWrEn) begin
      case (regAddr)
        ADDR_PEAK_SEL: st_nxt.cfg.peak_phase_enable = regWrData[PEAK_PHASE_ENABLE_LSB +: 3];
        ADDR_ACC_MODE: begin
          st_nxt.cfg.actMode = eac_actmode_e'(regWrData[ACTMODE_LSB +: 2]);
          st_nxt.cfg.reaMode = eac_reamode_e'(regWrData[REAMODE_LSB +: 2]);
          st_nxt.cfg.wiring = eac_wiring_e'(regWrData[WIRING_LSB +: 2]);
        end
        ADDR_CHAN_UP: st_nxt.cfg.vcPick = eac_vcpick_e'(regWrData[VCPICK_LSB +: 2]);
        ADDR_PEAK_CYC: st_nxt.cfg.peak_period_count = regWrData[PCYC_W-1:0];
        default: begin
        end
      endcase
    end

    // Read data stand only in the cycle after the strobe
    st_nxt.rdData = RD_ZERO;
    if (regRdEn) begin
      case (regAddr)
        ADDR_PEAK_SEL: st_nxt.rdData[PEAK_PHASE_ENABLE_LSB +: 3] = st_r.cfg.peak_phase_enable;
        ADDR_ACC_MODE: begin
          st_nxt.rdData[ACTMODE_LSB +: 2] = st_r.cfg.actMode;
          st_nxt.rdData[REAMODE_LSB +: 2] = st_r.cfg.reaMode;
          st_nxt.rdData[WIRING_LSB +: 2] = st_r.cfg.wiring;
        end
        ADDR_CHAN_UP: st_nxt.rdData[VCPICK_LSB +: 2] = st_r.cfg.vcPick;
        ADDR_PEAK_CYC: st_nxt.rdData[PCYC_W-1:0] = st_r.cfg.peak_period_count;
        default: st_nxt.rdData = RD_ZERO;
      endcase
    end

    // Sample results; energy accumulators live downstream and are untouched
    st_nxt.powValid = sampleValid;
    if (sampleValid) begin
      st_nxt.pow = powShaped;
      st_nxt.vRmsB = volt.vRmsB;
    end

    // Each enabled phase's crossing counts, so several phases end sooner
    st_nxt.peakEnd = 1'b0;
    zxEn = zxPulse & st_r.cfg.peak_phase_enable;
    zxHits = 2'(zxEn[0]) + 2'(zxEn[1]) + 2'(zxEn[2]);
    zxSum = {1'b0, st_r.zxCnt} + (PCYC_W + 1)'(zxHits);
    if (zxHits != 2'h0) begin
      if (zxSum >= {1'b0, st_r.cfg.peak_period_count}) begin
        st_nxt.zxCnt = '0;
        st_nxt.peakEnd = 1'b1;
      end else begin
        st_nxt.zxCnt = zxSum[PCYC_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.cfg.peak_phase_enable <= PEAK_SEL_RST;
      st_r.cfg.actMode <= ACT_SIGNED;
      st_r.cfg.reaMode <= REA_SIGNED;
      st_r.cfg.wiring <= WIRE_4W_3SENS;
      st_r.cfg.vcPick <= VC_PICK_C;
      st_r.cfg.peak_period_count <= PEAK_CYC_RST;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign powerValid = st_r.powValid;
  assign powerOut = st_r.pow;
  assign phaseBVoltRms = st_r.vRmsB;
  assign peakPhaseEnable = st_r.cfg.peak_phase_enable;
  assign peakPeriodEnd = st_r.peakEnd;
  assign cfgOut = st_r.cfg;

endmodule : eac_top

`default_nettype wire

// ---- eac_pkg.sv ----
/*
  Shared constants, enumerations and carrier structs for the energy
  accumulation configuration block.
  Assumes one core clock domain and sample data arriving as signed words.
*/
`default_nettype none

package eac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int PW = 2 * SAMPLE_W + 2;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int PCYC_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PEAK_SEL = 16'he700;
  localparam logic [ADDR_W-1:0] ADDR_ACC_MODE = 16'he701;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_UP = 16'he7f0;
  localparam logic [ADDR_W-1:0] ADDR_PEAK_CYC = 16'he7f1;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PEAK_PHASE_ENABLE_LSB = 2;
  localparam int ACTMODE_LSB = 0;
  localparam int REAMODE_LSB = 2;
  localparam int WIRING_LSB = 4;
  localparam int VCPICK_LSB = 12;
  localparam logic [2:0] PEAK_SEL_RST = 3'h7;
  localparam logic [PCYC_W-1:0] PEAK_CYC_RST = 8'h10;
  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_SIGNED = 2'h0,
    ACT_POS_ONLY = 2'h1,
    ACT_RSVD = 2'h2,
    ACT_ABS = 2'h3
  } eac_actmode_e;

  typedef enum logic [1:0] {
    REA_SIGNED = 2'h0,
    REA_RSVD = 2'h1,
    REA_BY_ACT_SIGN = 2'h2,
    REA_ABS = 2'h3
  } eac_reamode_e;

  typedef enum logic [1:0] {
    WIRE_4W_3SENS = 2'h0,
    WIRE_3W_DELTA = 2'h1,
    WIRE_4W_2SENS = 2'h2,
    WIRE_4W_DELTA = 2'h3
  } eac_wiring_e;

  typedef enum logic [1:0] {
    VC_PICK_C = 2'h0,
    VC_PICK_A = 2'h1,
    VC_PICK_B = 2'h2,
    VC_PICK_RSVD = 2'h3
  } eac_vcpick_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] vA;
    logic signed [SAMPLE_W-1:0] vB;
    logic signed [SAMPLE_W-1:0] vC;
    logic signed [SAMPLE_W-1:0] iA;
    logic signed [SAMPLE_W-1:0] iB;
    logic signed [SAMPLE_W-1:0] iC;
    logic signed [SAMPLE_W-1:0] iAq;
    logic signed [SAMPLE_W-1:0] iBq;
    logic signed [SAMPLE_W-1:0] iCq;
  } eac_samp_s;

  typedef struct packed {
    logic [2:0][SAMPLE_W:0] vPair;
    logic signed [SAMPLE_W:0] vRmsB;
  } eac_volt_s;

  typedef struct packed {
    logic [2:0][PW-1:0] actEnergy;
    logic [2:0][PW-1:0] actPulse;
    logic [2:0][PW-1:0] reaEnergy;
    logic [2:0][PW-1:0] reaPulse;
  } eac_pow_s;

  typedef struct packed {
    logic [2:0] peak_phase_enable;
    eac_actmode_e actMode;
    eac_reamode_e reaMode;
    eac_wiring_e wiring;
    eac_vcpick_e vcPick;
    logic [PCYC_W-1:0] peak_period_count;
  } eac_cfg_s;

  typedef struct packed {
    eac_cfg_s cfg;
    eac_pow_s pow;
    logic signed [SAMPLE_W:0] vRmsB;
    logic powValid;
    logic [PCYC_W-1:0] zxCnt;
    logic peakEnd;
    logic [DATA_W-1:0] rdData;
  } eac_top_st_s;

endpackage : eac_pkg

`default_nettype wire

// ---- eac_wiring_mux.sv ----
/*
  Voltage routing for the power path: service wiring and the phase C
  voltage pick.
  Assumes purely combinational use; the caller registers the results.
*/
`timescale 1ns/1ns
`default_nettype none

module eac_wiring_mux (
  input var eac_pkg::eac_samp_s samp,
  input var eac_pkg::eac_wiring_e wiring,
  input var eac_pkg::eac_vcpick_e vcPick,
  output var eac_pkg::eac_volt_s volt
);
  import eac_pkg::*;

  logic signed [SAMPLE_W:0] vA;
  logic signed [SAMPLE_W:0] vB;
  logic signed [SAMPLE_W:0] vC;
  logic signed [SAMPLE_W:0] vBEff;
  logic signed [SAMPLE_W:0] vForC;

  // ----------------------------------------------------------------
  // Phase B voltage per service type
  // ----------------------------------------------------------------
  always_comb begin
    vA = {samp.vA[SAMPLE_W-1], samp.vA};
    vB = {samp.vB[SAMPLE_W-1], samp.vB};
    vC = {samp.vC[SAMPLE_W-1], samp.vC};
    case (wiring)
      WIRE_3W_DELTA: vBEff = vA - vC;
      WIRE_4W_2SENS: vBEff = -vA - vC;
      WIRE_4W_DELTA: vBEff = -vA;
      default: vBEff = vB;
    endcase
  end

  // ----------------------------------------------------------------
  // Voltage paired with phase C current
  // ----------------------------------------------------------------
  always_comb begin
    case (vcPick)
      VC_PICK_A: vForC = vA;
      VC_PICK_B: vForC = vBEff;
      default: vForC = vC;
    endcase
  end

  always_comb begin
    volt.vPair[0] = vA;
    volt.vPair[1] = vBEff;
    volt.vPair[2] = vForC;
    // Line voltage A-C feeds the phase B rms in three-wire delta
    volt.vRmsB = vBEff;
  end

endmodule : eac_wiring_mux

`default_nettype wire

// ---- eac_accum_shaper.sv ----
/*
  Shapes one phase's active and reactive power for the energy registers
  and for the pulse converters according to the accumulation modes.
  Assumes powers far from the most negative value, so negation is safe.
*/
`timescale 1ns/1ns
`default_nettype none

module eac_accum_shaper (
  input wire logic [eac_pkg::PW-1:0] actIn,
  input wire logic [eac_pkg::PW-1:0] reaIn,
  input var eac_pkg::eac_actmode_e actMode,
  input var eac_pkg::eac_reamode_e reaMode,
  output logic [eac_pkg::PW-1:0] actEnergy,
  output logic [eac_pkg::PW-1:0] actPulse,
  output logic [eac_pkg::PW-1:0] reaEnergy,
  output logic [eac_pkg::PW-1:0] reaPulse
);
  import eac_pkg::*;

  logic actNeg;
  logic reaNeg;
  logic [PW-1:0] zeroP;

  // ----------------------------------------------------------------
  // Active power
  // ----------------------------------------------------------------
  always_comb begin
    zeroP = '0;
    actNeg = actIn[PW-1];
    reaNeg = reaIn[PW-1];
    case (actMode)
      ACT_POS_ONLY: begin
        actEnergy = actNeg ? zeroP : actIn;
        actPulse = actIn;
      end
      ACT_ABS: begin
        actEnergy = actNeg ? zeroP - actIn : actIn;
        actPulse = actNeg ? zeroP - actIn : actIn;
      end
      default: begin
        // Reserved code falls back to signed
        actEnergy = actIn;
        actPulse = actIn;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Reactive power
  // ----------------------------------------------------------------
  always_comb begin
    reaPulse = reaIn;
    case (reaMode)
      REA_BY_ACT_SIGN: reaEnergy = actNeg ? zeroP - reaIn : reaIn;
      REA_ABS: reaEnergy = reaNeg ? zeroP - reaIn : reaIn;
      default: reaEnergy = reaIn;
    endcase
  end

endmodule : eac_accum_shaper

`default_nettype wire

// ---- eac_top_sva.sv ----
/*
  Assertion checker for eac_top: register port, sample path and config mirror.
  Assumes one clock domain on ref_clk with rst_n as its asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module eac_top_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [eac_pkg::ADDR_W-1:0] regAddr,
  input wire logic [eac_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [eac_pkg::DATA_W-1:0] regRdData,
  input wire logic sampleValid,
  input var eac_pkg::eac_samp_s sampleIn,
  input wire logic powerValid,
  input var eac_pkg::eac_pow_s powerOut,
  input wire logic [eac_pkg::SAMPLE_W:0] phaseBVoltRms,
  input wire logic [2:0] peakPhaseEnable,
  input var eac_pkg::eac_cfg_s cfgOut
);
  import eac_pkg::*;
  // Line voltage for three-wire delta, formed at the sample edge
  logic signed [SAMPLE_W:0] diffAC;
  assign diffAC = sampleIn.vA - sampleIn.vC;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  pow_valid_a: assert property (sampleValid && clkEn |=> powerValid)
    else $error("powerValid missing after sample");
  pow_pulse_a: assert property (powerValid && clkEn && !sampleValid |=> !powerValid)
    else $error("powerValid longer than one cycle");
  rd_idle_a: assert property (clkEn && !regRdEn |=> regRdData == '0)
    else $error("read data not zero outside read");
  peak_hold_a: assert property (clkEn && !(regWrEn && regAddr == ADDR_PEAK_SEL)
    |=> $stable(peakPhaseEnable))
    else $error("peak enables changed without a write");
  peak_write_a: assert property (regWrEn && clkEn && regAddr == ADDR_PEAK_SEL
    |=> peakPhaseEnable == $past(regWrData[4:2]))
    else $error("peak enable write lost");
  mode_read_a: assert property (regRdEn && clkEn && regAddr == ADDR_ACC_MODE
    |=> regRdData == {10'h0, cfgOut.wiring, cfgOut.reaMode, cfgOut.actMode})
    else $error("mode read mismatch");
  act_pos_a: assert property (sampleValid && clkEn && cfgOut.actMode == ACT_POS_ONLY
    |=> !(powerOut.actEnergy[0][PW-1] | powerOut.actEnergy[1][PW-1]
    | powerOut.actEnergy[2][PW-1]))
    else $error("negative active energy in positive mode");
  act_same_a: assert property (sampleValid && clkEn && cfgOut.actMode != ACT_POS_ONLY
    |=> powerOut.actEnergy == powerOut.actPulse)
    else $error("active energy and pulse differ");
  rea_signed_a: assert property (sampleValid && clkEn && cfgOut.reaMode inside {REA_SIGNED,
    REA_RSVD} |=> powerOut.reaEnergy == powerOut.reaPulse)
    else $error("reactive energy and pulse differ");
  rea_abs_a: assert property (sampleValid && clkEn && cfgOut.reaMode == REA_ABS
    |=> !(powerOut.reaEnergy[0][PW-1] | powerOut.reaEnergy[1][PW-1]
    | powerOut.reaEnergy[2][PW-1]))
    else $error("negative reactive energy in absolute mode");
  delta_rms_a: assert property (sampleValid && clkEn && cfgOut.wiring == WIRE_3W_DELTA
    |=> phaseBVoltRms == $past(diffAC))
    else $error("phase B rms source not A minus C");
endmodule : eac_top_sva

bind eac_top eac_top_sva eac_top_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .sampleValid(sampleValid), .sampleIn(sampleIn),
  .powerValid(powerValid), .powerOut(powerOut), .phaseBVoltRms(phaseBVoltRms),
  .peakPhaseEnable(peakPhaseEnable), .cfgOut(cfgOut));

`default_nettype wire

// ---- tb_eac_top.sv ----
/*
  Self-checking bench for eac_top: registers, sample shaping, peak count.
  Assumes eac_pkg and the checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_eac_top;
  import eac_pkg::*;
  localparam int CW = $bits(eac_pow_s);
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic sampleValid = 1'b0;
  eac_samp_s sampleIn = '0;
  logic [2:0] zxPulse = '0;
  logic [DATA_W-1:0] regRdData;
  logic powerValid;
  eac_pow_s powerOut;
  logic [SAMPLE_W:0] phaseBVoltRms;
  logic [2:0] peakPhaseEnable;
  logic peakPeriodEnd;
  eac_cfg_s cfgOut;
  int errCount = 0;
  int nCompared = 0;
  logic [31:0] rng = 32'h0000005d;
  logic [7:0] mode = '0;
  logic [15:0] regA [5] = '{16'he700, 16'he701, 16'he7f0, 16'he7f1, 16'he702};
  logic [15:0] rstV [5] = '{16'h001c, 16'h0000, 16'h0000, 16'h0010, 16'h0000};
  logic [15:0] mskV [5] = '{16'h001c, 16'h003f, 16'h3000, 16'h00ff, 16'h0000};

  always #10 ref_clk = ~ref_clk;

  eac_top eac_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleValid(sampleValid), .sampleIn(sampleIn), .zxPulse(zxPulse),
    .powerValid(powerValid), .powerOut(powerOut), .phaseBVoltRms(phaseBVoltRms),
    .peakPhaseEnable(peakPhaseEnable), .peakPeriodEnd(peakPeriodEnd), .cfgOut(cfgOut));

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [23:0] rnd();
    repeat (7) rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
    return rng[23:0];
  endfunction : rnd

  function automatic logic signed [SAMPLE_W:0] routeB(input eac_samp_s s, input logic [1:0] w);
    logic signed [SAMPLE_W:0] a;
    logic signed [SAMPLE_W:0] c;
    a = s.vA;
    c = s.vC;
    case (w)
      2'h0: return s.vB;
      2'h1: return a - c;
      2'h2: return -a - c;
      default: return -a;
    endcase
  endfunction : routeB

  // Mode byte is {pick, wiring, reactive, active}
  function automatic eac_pow_s expPow(input eac_samp_s s, input logic [7:0] m);
    logic signed [SAMPLE_W:0] v [3];
    logic signed [SAMPLE_W-1:0] i [3];
    logic signed [SAMPLE_W-1:0] q [3];
    logic signed [PW-1:0] p;
    logic signed [PW-1:0] r;
    eac_pow_s o;
    v[0] = s.vA;
    v[1] = routeB(s, m[5:4]);
    v[2] = s.vC;
    if (m[7:6] == 2'h1) v[2] = v[0];
    if (m[7:6] == 2'h2) v[2] = v[1];
    i = '{s.iA, s.iB, s.iC};
    q = '{s.iAq, s.iBq, s.iCq};
    for (int k = 0; k < 3; k++) begin
      p = v[k] * i[k];
      r = v[k] * q[k];
      o.actPulse[k] = (m[1:0] == 2'h3 && p < 0) ? -p : p;
      o.actEnergy[k] = (m[1:0] == 2'h1 && p < 0) ? '0 : o.actPulse[k];
      o.reaPulse[k] = r;
      o.reaEnergy[k] = ((m[3:2] == 2'h2 && p < 0) || (m[3:2] == 2'h3 && r < 0)) ? -r : r;
    end
    return o;
  endfunction : expPow

  // ----------------------------------------------------------------
  // Drivers and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [CW-1:0] g, input logic [CW-1:0] e);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rd

  // A write riding on the sample edge must only reach the next sample
  task automatic smp(input logic wrToo, input logic [5:0] d);
    eac_samp_s s;
    eac_pow_s e;
    logic signed [SAMPLE_W:0] vb;
    for (int k = 0; k < 9; k++) s[k*24 +: 24] = rnd();
    e = expPow(s, mode);
    vb = routeB(s, mode[5:4]);
    @(posedge ref_clk);
    sampleValid <= 1'b1;
    sampleIn <= s;
    regWrEn <= wrToo;
    regAddr <= ADDR_ACC_MODE;
    regWrData <= {10'h0, d};
    @(posedge ref_clk);
    sampleValid <= 1'b0;
    regWrEn <= 1'b0;
    #1 chk(powerValid, 1'b1);
    // Phase B terms stay raw in three-wire delta; software mutes them downstream
    chk(powerOut, e);
    chk(phaseBVoltRms, {vb});
    if (wrToo) mode[5:0] = d;
  endtask : smp

  task automatic zx(input logic [2:0] z, input logic e);
    @(posedge ref_clk);
    zxPulse <= z;
    @(posedge ref_clk);
    zxPulse <= '0;
    #1 chk(peakPeriodEnd, e);
  endtask : zx

  task automatic stopTest();
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stopTest

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    errCount++;
    stopTest();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(cfgOut, {3'h7, 8'h00, 8'h10});
    for (int k = 0; k < 5; k++) rd(regA[k], rstV[k]);
    for (int k = 0; k < 5; k++) wr(regA[k], 16'hffff);
    for (int k = 0; k < 5; k++) rd(regA[k], mskV[k]);
    // Frozen clock enable must drop the write
    @(posedge ref_clk) clkEn <= 1'b0;
    wr(ADDR_PEAK_CYC, 16'h0005);
    @(posedge ref_clk) clkEn <= 1'b1;
    rd(ADDR_PEAK_CYC, 16'h00ff);
    wr(ADDR_PEAK_CYC, 16'h0002);
    zx(3'b011, 1'b1);
    zx(3'b001, 1'b0);
    zx(3'b100, 1'b1);
    wr(ADDR_PEAK_SEL, 16'h0014);
    #1 chk(peakPhaseEnable, 3'b101);
    wr(ADDR_PEAK_CYC, 16'h0003);
    repeat (3) zx(3'b010, 1'b0);
    zx(3'b101, 1'b0);
    zx(3'b001, 1'b1);
    for (int n = 0; n < 256; n++) begin
      wr(ADDR_CHAN_UP, {2'h0, n[7:6], 12'h000});
      wr(ADDR_ACC_MODE, {10'h0, n[5:0]});
      mode = n[7:0];
      smp(1'b0, 6'h0);
      if (n[1:0] == 2'h0) smp(1'b1, n[5:0] ^ 6'h2a);
      if (n[1:0] == 2'h0) smp(1'b0, 6'h0);
    end
    stopTest();
  end
endmodule : tb_eac_top

`default_nettype wire
